/* dac_ctrl_map.vh */
// Purpose: Register offsets, field positions, reset values and timing
// Assumes: 7-bit register address, 9-bit register data
// Notes: Included by the control bank and the clock generator
`ifndef DAC_CTRL_MAP_VH
`define DAC_CTRL_MAP_VH

`define ADDR_DAC_CHANNEL_CONTROL 7'h02
`define ADDR_DEEMPHASIS_SELECT 7'h09
`define ADDR_INTERFACE_POWER_CONTROL 7'h0a
`define ADDR_LEGACY_CONVERTER_CONTROL 7'h0c
`define ADDR_CHANNEL4_CONTROL 7'h0f
`define ADDR_SOFT_RESET 7'h1f

`define RST_DAC_CHANNEL_CONTROL 9'h120
`define RST_DEEMPHASIS_SELECT 9'h000
`define RST_INTERFACE_POWER_CONTROL 9'h080
`define RST_LEGACY_CONVERTER_CONTROL 9'h000
`define RST_CHANNEL4_CONTROL 9'h080

// dac_channel_control
`define BIT_GLOBAL_CHANNEL_SELECT_A 1
`define BIT_GLOBAL_GLOBAL_DAC_POWERDOWN 2
// deemphasis_select
`define FLD_CHANNEL_SELECT_A_HI 8
`define FLD_CHANNEL_SELECT_A_LO 6
// interface_power_control
`define FLD_DISABLE_HI 3
`define FLD_DISABLE_LO 1
`define BIT_MASTER_GLOBAL_DAC_POWERDOWN 4
`define BIT_MASTER_SELECT 5
`define FLD_RATE_HI 8
`define FLD_RATE_LO 6
// legacy_converter_control
`define BIT_MPD_LEGACY 6
// channel4_control
`define BIT_CH4_DISABLE 1
`define BIT_CH4_CHANNEL_SELECT_A 4
`define BIT_MPD_CH4 5
`define BIT_ZFM_HI 6
`define FLD_ZFM_HI 8
`define FLD_ZFM_LO 7

`define RATE_128 3'h0
`define RATE_192 3'h1
`define RATE_256 3'h2
`define RATE_384 3'h3
`define RATE_512 3'h4
`define RATE_768 3'h5

`define ZERO_RUN_LEN 11'h400
`define CTL_FRAME_BITS 5'h10
`define BCLK_PER_FRAME 64
`define FILTER_INIT_CYCLES 8'h40

`endif

/* frame_clock_gen.v */
// Purpose: Frame and bit clock generator for interface master mode
// Assumes: Runs on the master clock, 64 bit clocks per frame
// Notes: Outputs held low while disabled
`timescale 1ns/1ps
`include "dac_ctrl_map.vh"

module frame_clock_gen #(
   parameter CW = 10
) (
   input wire clock,
   input wire rst,
   input wire enable,
   input wire [2:0] rate,
   output reg frame_clk,
   output reg bit_clk
);

   reg [CW-1:0] frame_cnt;
   reg [3:0] bit_cnt;
   reg [2:0] rate_q;
   wire [CW-1:0] ratio;
   wire [3:0] bit_div;

   function [CW-1:0] ratio_of;
      input [2:0] code;
      begin
         case (code)
            `RATE_128: ratio_of = 10'd128;
            `RATE_192: ratio_of = 10'd192;
            `RATE_256: ratio_of = 10'd256;
            `RATE_384: ratio_of = 10'd384;
            `RATE_512: ratio_of = 10'd512;
            `RATE_768: ratio_of = 10'd768;
            default: ratio_of = 10'd256;
         endcase
      end
   endfunction

   assign ratio = ratio_of(rate);
   assign bit_div = ratio[9:6];

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         frame_cnt <= {CW{1'b0}};
         bit_cnt <= 4'h0;
         frame_clk <= 1'b0;
         bit_clk <= 1'b0;
         rate_q <= 3'h0;
      end else if (!enable) begin
         frame_cnt <= {CW{1'b0}};
         bit_cnt <= 4'h0;
         frame_clk <= 1'b0;
         bit_clk <= 1'b0;
         rate_q <= rate;
      end else if (rate != rate_q) begin
         // Restart on ratio change, no stretched half periods
         frame_cnt <= {CW{1'b0}};
         bit_cnt <= 4'h0;
         frame_clk <= 1'b0;
         bit_clk <= 1'b0;
         rate_q <= rate;
      end else begin
         if (frame_cnt >= ratio - 10'd1)
            frame_cnt <= {CW{1'b0}};
         else
            frame_cnt <= frame_cnt + 10'd1;
         if (bit_cnt >= bit_div - 4'h1 || frame_cnt >= ratio - 10'd1)
            bit_cnt <= 4'h0;
         else
            bit_cnt <= bit_cnt + 4'h1;
         // Left half of frame high, bit clock low for first half period
         frame_clk <= (frame_cnt < {1'b0, ratio[CW-1:1]});
         bit_clk <= (bit_cnt >= {1'b0, bit_div[3:1]});
      end
   end

endmodule

/* dac_channel_control_regs.v */
// Purpose: Control registers and decode for a four-channel audio DAC
// Assumes: 3-wire control port, 16-bit frames, address then data, MSB first
// Notes: Control pins pass a three-stage synchroniser before use
`timescale 1ns/1ps
`include "dac_ctrl_map.vh"

// Contract
// - Per-channel de-emphasis from four-bit selector
// - Global de-emphasis bit forces all channels
// - Global power-down powers down all channels
// - Power-down clears history, keeps registers
// - Clearing power-down reinitialises interpolation filters
// - Disable bit puts channel in low power
// - Master power-down kills everything including midrail; clock enables still follow master select and the mute pin stays driven
// - Master select drives frame, bit clocks
// - Rate field sets master clocks per frame
// - Frame and bit clocks divided from master
// - Mute decode disable is OR of copies
// - Decode off: pin high mutes all
// - Decode on: selector picks muted channels
// - Pin output shows selected zero flags
// - Zero flag after 1024 zero samples
// - Selector table: all, single, pairs, triple
module dac_channel_control_regs #(
   parameter ZERO_RUN = 11,
   parameter INIT_CYCLES = 8
) (
   input wire clock,
   input wire rst,
   input wire ctl_latch,
   input wire ctl_sclk,
   input wire ctl_sdin,
   input wire mute_pin_in,
   input wire [3:0] sample_valid,
   input wire [3:0] sample_is_zero,
   output reg [3:0] channel_select_a_active,
   output reg [3:0] channel_powered_down,
   output reg midrail_off,
   output reg history_clear,
   output reg filter_reinit,
   output reg [3:0] soft_mute,
   output reg [3:0] zero_flag,
   output reg mute_pin_out,
   output reg mute_pin_oe,
   output reg frame_clk_out,
   output reg frame_clk_oe,
   output reg bit_clk_out,
   output reg bit_clk_oe
);

   localparam ST_RUN = 3'b001;
   localparam ST_HALT = 3'b010;
   localparam ST_INIT = 3'b100;

   reg [8:0] dac_channel_control;
   reg [8:0] deemphasis_select;
   reg [8:0] interface_power_control;
   reg [8:0] legacy_converter_control;
   reg [8:0] channel4_control;

   reg [2:0] latch_sync;
   reg [2:0] sclk_sync;
   reg [2:0] sdin_sync;
   reg [2:0] mute_sync;
   reg latch_level;
   reg sclk_level;
   reg sdin_level;
   reg mute_level;
   reg latch_prev;
   reg sclk_prev;
   reg [15:0] shift_word;
   reg [4:0] bit_count;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [INIT_CYCLES-1:0] init_cnt;
   reg [ZERO_RUN-1:0] zero_cnt [0:3];
   integer zi;

   wire sclk_rise;
   wire latch_rise;
   wire [6:0] wr_addr;
   wire [8:0] wr_data;
   wire wr_commit;
   wire global_pd;
   wire master_pd;
   wire master_mode;
   wire [2:0] rate;
   wire [3:0] channel_select_a_sel;
   wire [3:0] disable_sel;
   wire [2:0] zfm_sel;
   wire mpd_eff;
   wire [3:0] zfm_mask;
   wire [3:0] mute_group;
   wire gen_frame;
   wire gen_bit;

   // Channel group picked by the three-bit zero-flag mute selector
   function [3:0] zfm_decode;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: zfm_decode = 4'hf;
            3'h1: zfm_decode = 4'h1;
            3'h2: zfm_decode = 4'h2;
            3'h3: zfm_decode = 4'h4;
            3'h4: zfm_decode = 4'h8;
            3'h5: zfm_decode = 4'h3;
            3'h6: zfm_decode = 4'h7;
            3'h7: zfm_decode = 4'hc;
            default: zfm_decode = 4'hf;
         endcase
      end
   endfunction

   // Filtered pin level: follows once stages two and three agree
   function next_level;
      input [2:0] sync;
      input cur;
      begin
         next_level = (sync[1] == sync[2]) ? sync[2] : cur;
      end
   endfunction

   // Control pin synchronisers
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         latch_sync <= 3'h7;
         sclk_sync <= 3'h0;
         sdin_sync <= 3'h0;
         mute_sync <= 3'h0;
         latch_level <= 1'b1;
         sclk_level <= 1'b0;
         sdin_level <= 1'b0;
         mute_level <= 1'b0;
         latch_prev <= 1'b1;
         sclk_prev <= 1'b0;
      end else begin
         latch_sync <= {latch_sync[1:0], ctl_latch};
         sclk_sync <= {sclk_sync[1:0], ctl_sclk};
         sdin_sync <= {sdin_sync[1:0], ctl_sdin};
         mute_sync <= {mute_sync[1:0], mute_pin_in};
         latch_level <= next_level(latch_sync, latch_level);
         sclk_level <= next_level(sclk_sync, sclk_level);
         sdin_level <= next_level(sdin_sync, sdin_level);
         mute_level <= next_level(mute_sync, mute_level);
         latch_prev <= latch_level;
         sclk_prev <= sclk_level;
      end
   end

   assign sclk_rise = sclk_level & ~sclk_prev;
   assign latch_rise = latch_level & ~latch_prev;
   assign wr_addr = shift_word[15:9];
   assign wr_data = shift_word[8:0];
   assign wr_commit = latch_rise && (bit_count >= `CTL_FRAME_BITS);

   // Serial word assembly, latch low frames the transfer
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         shift_word <= 16'h0000;
         bit_count <= 5'h00;
      end else if (latch_rise) begin
         bit_count <= 5'h00;
      end else if (sclk_rise && !latch_level) begin
         shift_word <= {shift_word[14:0], sdin_level};
         if (bit_count < `CTL_FRAME_BITS)
            bit_count <= bit_count + 5'h01;
      end
   end

   // Register writes; registers untouched by any power-down
   // settings preserved
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         dac_channel_control <= `RST_DAC_CHANNEL_CONTROL;
         deemphasis_select <= `RST_DEEMPHASIS_SELECT;
         interface_power_control <= `RST_INTERFACE_POWER_CONTROL;
         legacy_converter_control <= `RST_LEGACY_CONVERTER_CONTROL;
         channel4_control <= `RST_CHANNEL4_CONTROL;
      end else if (wr_commit) begin
         case (wr_addr)
            `ADDR_DAC_CHANNEL_CONTROL:
               dac_channel_control <= wr_data;
            `ADDR_DEEMPHASIS_SELECT:
               deemphasis_select <= wr_data;
            `ADDR_INTERFACE_POWER_CONTROL:
               interface_power_control <= wr_data;
            `ADDR_LEGACY_CONVERTER_CONTROL:
               legacy_converter_control <= wr_data;
            `ADDR_CHANNEL4_CONTROL:
               channel4_control <= wr_data;
            `ADDR_SOFT_RESET: begin
               dac_channel_control <= `RST_DAC_CHANNEL_CONTROL;
               deemphasis_select <= `RST_DEEMPHASIS_SELECT;
               interface_power_control <= `RST_INTERFACE_POWER_CONTROL;
               legacy_converter_control <= `RST_LEGACY_CONVERTER_CONTROL;
               channel4_control <= `RST_CHANNEL4_CONTROL;
            end
            default: begin
            end
         endcase
      end
   end

   assign global_pd = dac_channel_control[`BIT_GLOBAL_GLOBAL_DAC_POWERDOWN];
   assign master_pd = interface_power_control[`BIT_MASTER_GLOBAL_DAC_POWERDOWN];
   assign master_mode = interface_power_control[`BIT_MASTER_SELECT];
   assign rate = interface_power_control[`FLD_RATE_HI:`FLD_RATE_LO];
   assign channel_select_a_sel = {channel4_control[`BIT_CH4_CHANNEL_SELECT_A],
      deemphasis_select[`FLD_CHANNEL_SELECT_A_HI:`FLD_CHANNEL_SELECT_A_LO]};
   assign disable_sel = {channel4_control[`BIT_CH4_DISABLE],
      interface_power_control[`FLD_DISABLE_HI:`FLD_DISABLE_LO]};
   assign zfm_sel = {channel4_control[`BIT_ZFM_HI],
      channel4_control[`FLD_ZFM_HI:`FLD_ZFM_LO]};
   assign mpd_eff = legacy_converter_control[`BIT_MPD_LEGACY] |
      channel4_control[`BIT_MPD_CH4];
   assign zfm_mask = zfm_decode(zfm_sel);
   assign mute_group = mpd_eff ? 4'hf : zfm_mask;

   // Power and de-emphasis outputs
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         channel_select_a_active <= 4'h0;
         channel_powered_down <= 4'h0;
         midrail_off <= 1'b0;
         history_clear <= 1'b0;
      end else begin
         channel_select_a_active <= dac_channel_control[`BIT_GLOBAL_CHANNEL_SELECT_A] ?
            4'hf : channel_select_a_sel;
         channel_powered_down <= (global_pd | master_pd) ?
            4'hf : disable_sel;
         midrail_off <= master_pd;
         history_clear <= global_pd | master_pd;
      end
   end

   // Filter restart sequencing after power-down release
   always @* begin
      next_state = state;
      case (state)
         ST_RUN:
            if (global_pd || master_pd)
               next_state = ST_HALT;
         ST_HALT:
            if (!global_pd && !master_pd)
               next_state = ST_INIT;
         ST_INIT:
            if (global_pd || master_pd)
               next_state = ST_HALT;
            else if (init_cnt == {INIT_CYCLES{1'b1}})
               next_state = ST_RUN;
         default:
            next_state = ST_RUN;
      endcase
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ST_RUN;
         init_cnt <= {INIT_CYCLES{1'b0}};
         filter_reinit <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state == ST_INIT)
            init_cnt <= init_cnt + {{(INIT_CYCLES-1){1'b0}}, 1'b1};
         else
            init_cnt <= {INIT_CYCLES{1'b0}};
         filter_reinit <= (next_state == ST_INIT);
      end
   end

   // Per-channel consecutive zero sample counters
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         for (zi = 0; zi < 4; zi = zi + 1)
            zero_cnt[zi] <= {ZERO_RUN{1'b0}};
         zero_flag <= 4'h0;
      end else begin
         for (zi = 0; zi < 4; zi = zi + 1) begin
            if (history_clear) begin
               zero_cnt[zi] <= {ZERO_RUN{1'b0}};
               zero_flag[zi] <= 1'b0;
            end else if (sample_valid[zi]) begin
               if (!sample_is_zero[zi]) begin
                  zero_cnt[zi] <= {ZERO_RUN{1'b0}};
                  zero_flag[zi] <= 1'b0;
               end else if (zero_cnt[zi] < `ZERO_RUN_LEN) begin
                  zero_cnt[zi] <= zero_cnt[zi] + 11'h001;
                  zero_flag[zi] <= (zero_cnt[zi] == `ZERO_RUN_LEN - 11'h001);
               end
            end
         end
      end
   end

   // Mute pin drive and soft mute from the observed pin level
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         mute_pin_out <= 1'b0;
         mute_pin_oe <= 1'b0;
         soft_mute <= 4'h0;
      end else begin
         mute_pin_out <= ((zero_flag & zfm_mask) == zfm_mask);
         mute_pin_oe <= 1'b1;
         soft_mute <= mute_level ? mute_group : 4'h0;
      end
   end

   frame_clock_gen #(
      .CW(10)
   ) u_clkgen (
      .clock(clock),
      .rst(rst),
      .enable(master_mode & ~master_pd),
      .rate(rate),
      .frame_clk(gen_frame),
      .bit_clk(gen_bit)
   );

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         frame_clk_out <= 1'b0;
         bit_clk_out <= 1'b0;
         frame_clk_oe <= 1'b0;
         bit_clk_oe <= 1'b0;
      end else begin
         frame_clk_out <= gen_frame;
         bit_clk_out <= gen_bit;
         frame_clk_oe <= master_mode;
         bit_clk_oe <= master_mode;
      end
   end

endmodule

/* ctl_host.sv */
// Purpose: Host model driving the three-wire control port
// Assumes: Runs off the device master clock
// Notes: Data line shows the inverse of its last bit between frames
`timescale 1ns/1ps
module ctl_host #(
   parameter PH = 4
) (
   input wire clock,
   output logic ctl_latch,
   output logic ctl_sclk,
   output logic ctl_sdin
);
   initial begin
      ctl_latch = 1'b1;
      ctl_sclk = 1'b0;
      ctl_sdin = 1'b0;
   end
   // One 16-bit frame, address first
   task automatic send(input logic [6:0] a, input logic [8:0] d);
      logic [15:0] w;
      w = {a, d};
      @(posedge clock);
      #1;
      ctl_latch = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         ctl_sdin = w[i];
         ctl_sclk = 1'b0;
         repeat (PH) @(posedge clock);
         #1;
         ctl_sclk = 1'b1;
         repeat (PH) @(posedge clock);
         #1;
      end
      ctl_latch = 1'b1;
      ctl_sdin = ~w[0];
   endtask
endmodule

/* dac_channel_control_regs_properties.sv */
// Purpose: Port-level checks of the DAC control bank
// Assumes: Single clock domain, reset high
// Notes: Attached by bind from the bench
`timescale 1ns/1ps
module dac_channel_control_regs_properties #(
   parameter ZERO_RUN = 11,
   parameter INIT_CYCLES = 8
) (
   input wire clock,
   input wire rst,
   input wire ctl_latch,
   input wire ctl_sclk,
   input wire ctl_sdin,
   input wire mute_pin_in,
   input wire [3:0] sample_valid,
   input wire [3:0] sample_is_zero,
   input wire [3:0] channel_select_a_active,
   input wire [3:0] channel_powered_down,
   input wire midrail_off,
   input wire history_clear,
   input wire filter_reinit,
   input wire [3:0] soft_mute,
   input wire [3:0] zero_flag,
   input wire mute_pin_out,
   input wire mute_pin_oe,
   input wire frame_clk_out,
   input wire frame_clk_oe,
   input wire bit_clk_out,
   input wire bit_clk_oe
);
   logic [7:0] pin_hist;
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         pin_hist <= 8'h00;
      else
         pin_hist <= {pin_hist[6:0], mute_pin_in};
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_pd_held;
      history_clear [*2];
   endsequence
   sequence s_bit_high;
      bit_clk_out [*6];
   endsequence
   a_pd_all: assert property (history_clear |->
      channel_powered_down == 4'hf) else $error("power-down not global");
   a_midrail_all: assert property (midrail_off |->
      history_clear && channel_powered_down == 4'hf)
      else $error("master power-down incomplete");
   a_pd_flag: assert property (s_pd_held |-> zero_flag == 4'h0)
      else $error("zero flag kept in power-down");
   a_reinit_after: assert property ($fell(history_clear) |->
      ##[0:2] filter_reinit) else $error("no filter reinit");
   a_oe_pair: assert property (frame_clk_oe == bit_clk_oe)
      else $error("clock enables differ");
   a_bit_half: assert property (s_bit_high |=> !bit_clk_out)
      else $error("bit clock high too long");
   a_zero_rise: assert property ($rose(zero_flag[0]) |->
      $past(sample_valid[0] & sample_is_zero[0]))
      else $error("zero flag without zero sample");
   a_flag_clear: assert property (
      sample_valid[0] && !sample_is_zero[0] |=> !zero_flag[0])
      else $error("zero flag kept after data");
   a_mute_src: assert property (soft_mute != 4'h0 |->
      pin_hist[6:1] != 6'h00) else $error("mute without pin");
   a_pin_flags: assert property (mute_pin_out |->
      (zero_flag | $past(zero_flag)) != 4'h0)
      else $error("mute pin high without flag");
   a_mute_oe_on: assert property (!$past(rst) |-> mute_pin_oe)
      else $error("mute pin not driven");
endmodule

/* dac_channel_control_regs_bench.sv */
// Purpose: Self-checking bench for the DAC control bank
// Assumes: Host model writes over the three-wire port
// Notes: Filter reinit counter shortened to 3 bits
`timescale 1ns/1ps
module dac_channel_control_regs_bench;
   logic clock, rst, ext_en, ext_lvl;
   logic [3:0] sample_valid, sample_is_zero;
   wire ctl_latch, ctl_sclk, ctl_sdin, mute_pin_in;
   wire [3:0] channel_select_a_active, channel_powered_down, soft_mute, zero_flag;
   wire midrail_off, history_clear, filter_reinit, mute_pin_out, mute_pin_oe;
   wire frame_clk_out, frame_clk_oe, bit_clk_out, bit_clk_oe;
   int n_errors = 0;
   int total_checks = 0;
   int p;
   localparam int rat[6] = '{128, 192, 256, 384, 512, 768};
   localparam logic [3:0] grp[8] = '{4'hf, 4'h1, 4'h2, 4'h4, 4'h8,
      4'h3, 4'h7, 4'hc};
   // Weak pin drive loses to an external driver
   assign mute_pin_in = ext_en ? ext_lvl : (mute_pin_out & mute_pin_oe);
   ctl_host i_host (.clock(clock), .ctl_latch(ctl_latch),
      .ctl_sclk(ctl_sclk), .ctl_sdin(ctl_sdin));
   dac_channel_control_regs #(.ZERO_RUN(11), .INIT_CYCLES(3)) i_dut (
      .clock(clock), .rst(rst), .ctl_latch(ctl_latch),
      .ctl_sclk(ctl_sclk), .ctl_sdin(ctl_sdin), .mute_pin_in(mute_pin_in),
      .sample_valid(sample_valid), .sample_is_zero(sample_is_zero),
      .channel_select_a_active(channel_select_a_active),
      .channel_powered_down(channel_powered_down),
      .midrail_off(midrail_off), .history_clear(history_clear),
      .filter_reinit(filter_reinit), .soft_mute(soft_mute),
      .zero_flag(zero_flag), .mute_pin_out(mute_pin_out),
      .mute_pin_oe(mute_pin_oe), .frame_clk_out(frame_clk_out),
      .frame_clk_oe(frame_clk_oe), .bit_clk_out(bit_clk_out),
      .bit_clk_oe(bit_clk_oe));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      i_host.send(a, d);
      repeat (8) @(posedge clock);
      #1;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic zeros(input int n, input logic z);
      repeat (n) begin
         sample_valid = 4'h1;
         sample_is_zero = {3'b000, z};
         waitc(1);
      end
      sample_valid = 4'h0;
      waitc(1);
   endtask
   // Cycles between two rising edges of a generated clock
   task automatic meas(input logic b, output int per);
      int r0;
      logic q, prev;
      r0 = -1;
      per = 0;
      prev = 1'b1;
      for (int i = 0; i < 2000 && per == 0; i++) begin
         waitc(1);
         q = b ? bit_clk_out : frame_clk_out;
         if (q === 1'b1 && prev === 1'b0) begin
            if (r0 < 0)
               r0 = i;
            else
               per = i - r0;
         end
         prev = q;
      end
   endtask
   task automatic summarize;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #3000000;
      n_errors++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      ext_en = 1'b0;
      ext_lvl = 1'b0;
      sample_valid = 4'h0;
      sample_is_zero = 4'h0;
      waitc(4);
      rst = 1'b0;
      waitc(2);
      chk(channel_select_a_active, 4'h0);
      chk(channel_powered_down, 4'h0);
      chk({frame_clk_oe, bit_clk_oe}, 2'b00);
      wr(7'h09, 9'h140);
      wr(7'h0f, 9'h090);
      chk(channel_select_a_active, 4'hd);
      wr(7'h02, 9'h122);
      chk(channel_select_a_active, 4'hf);
      wr(7'h02, 9'h120);
      wr(7'h11, 9'h1ff);
      chk(channel_select_a_active, 4'hd);
      wr(7'h0a, 9'h084);
      wr(7'h0f, 9'h092);
      chk(channel_powered_down, 4'ha);
      wr(7'h02, 9'h124);
      chk(channel_powered_down, 4'hf);
      chk(history_clear, 1'b1);
      wr(7'h02, 9'h120);
      chk(channel_powered_down, 4'ha);
      chk({history_clear, filter_reinit}, 2'b01);
      waitc(8);
      chk(filter_reinit, 1'b0);
      wr(7'h02, 9'h124);
      wr(7'h0a, 9'h094);
      chk(midrail_off, 1'b1);
      wr(7'h02, 9'h120);
      chk(channel_powered_down, 4'hf);
      wr(7'h0a, 9'h084);
      chk({midrail_off, channel_powered_down}, 5'h0a);
      wr(7'h1f, 9'h000);
      chk({channel_select_a_active, channel_powered_down}, 8'h00);
      for (int c = 0; c < 6; c++) begin
         wr(7'h0a, {c[2:0], 6'h20});
         chk(frame_clk_oe, 1'b1);
         meas(1'b0, p);
         chk(p[15:0], rat[c]);
         meas(1'b1, p);
         chk(p[15:0], rat[c] / 64);
      end
      wr(7'h0a, 9'h1a0);
      meas(1'b0, p);
      chk(p[15:0], 16'h0100);
      wr(7'h0a, 9'h080);
      chk({frame_clk_oe, bit_clk_oe}, 2'b00);
      zeros(1023, 1'b1);
      chk(zero_flag, 4'h0);
      zeros(1, 1'b1);
      chk(zero_flag, 4'h1);
      waitc(8);
      chk(mute_pin_out, 1'b1);
      chk(soft_mute, 4'h1);
      zeros(1, 1'b0);
      chk(zero_flag, 4'h0);
      waitc(8);
      chk(soft_mute, 4'h0);
      ext_en = 1'b1;
      ext_lvl = 1'b1;
      for (int s = 0; s < 8; s++) begin
         wr(7'h0f, {s[1:0], s[2], 6'h00});
         chk(soft_mute, grp[s]);
      end
      wr(7'h0c, 9'h040);
      chk(soft_mute, 4'hf);
      wr(7'h0c, 9'h000);
      chk(soft_mute, 4'hc);
      wr(7'h0f, 9'h1e0);
      chk(soft_mute, 4'hf);
      ext_lvl = 1'b0;
      waitc(8);
      chk(soft_mute, 4'h0);
      summarize();
   end
endmodule
bind dac_channel_control_regs dac_channel_control_regs_properties #(
   .ZERO_RUN(ZERO_RUN), .INIT_CYCLES(INIT_CYCLES)) i_props (
   .clock(clock), .rst(rst), .ctl_latch(ctl_latch), .ctl_sclk(ctl_sclk),
   .ctl_sdin(ctl_sdin), .mute_pin_in(mute_pin_in),
   .sample_valid(sample_valid), .sample_is_zero(sample_is_zero),
   .channel_select_a_active(channel_select_a_active),
   .channel_powered_down(channel_powered_down),
   .midrail_off(midrail_off), .history_clear(history_clear),
   .filter_reinit(filter_reinit), .soft_mute(soft_mute),
   .zero_flag(zero_flag), .mute_pin_out(mute_pin_out),
   .mute_pin_oe(mute_pin_oe), .frame_clk_out(frame_clk_out),
   .frame_clk_oe(frame_clk_oe), .bit_clk_out(bit_clk_out),
   .bit_clk_oe(bit_clk_oe));
